// ---- logic/sar_link_defs.svh ----
// Constants shared by both ends of the converter link
// Function
// - Trigger rising edge holds input, starts conversion
// - Trigger acts regardless of select and read
// - Conversion lasts 26 to 28 clock periods
// - Conversion time at most 15 us
// - Busy low, bus floating during conversion
// - Busy returns high when result ready
// - Host reads by lowering select and read
// - Bus driven only when select and read low
// - Select low, read high keeps bus floating
// - Device selected only while select low
// - Power select low means power save
// - Host supplies nominal 2 MHz conversion clock
// - Conversion clock duty between 40 and 60
// - At least 5 us acquisition before trigger
// - Trigger spacing at least 20 us, 50 kHz
// - Result is 12-bit straight binary code
`ifndef SAR_LINK_DEFS_SVH
`define SAR_LINK_DEFS_SVH
`define RES_W 12
`define CLK_HZ 100000000
`define CONV_CLK_HZ 2000000
`define CONV_DIV (`CLK_HZ / `CONV_CLK_HZ)
`define CONV_HIGH_CYC (`CONV_DIV / 2)
`define CONV_PERIODS 27
`define CONV_MAX_US 15
`define ACQ_US 5
`define ACQ_CYC ((`ACQ_US * (`CLK_HZ / 1000000)))
`define SAMPLE_US 20
`define SAMPLE_CYC ((`SAMPLE_US * (`CLK_HZ / 1000000)))
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define RD_LAST 2
`define BUSY_LAG 3
`endif

// ---- logic/sar_link_pkg.sv ----
// Types shared by both ends of the converter link
package sar_link_pkg;
  typedef logic [11:0] result_t;
endpackage

// ---- logic/sar_link_if.sv ----
// Pin-level link between host and converter
interface sar_link_if;
  logic conversion_trigger_n;
  logic conversion_clock_in;
  logic cs_n;
  logic rd_n;
  logic power_sel;
  logic busy_n;
  logic [11:0] result_bus_o;
  logic [11:0] result_bus_oe;
  logic [11:0] result_bus;
  // Resolved bus level seen by the host
  assign result_bus = result_bus_o & result_bus_oe;
  modport dev (input conversion_trigger_n, conversion_clock_in, cs_n, rd_n, power_sel,
    output busy_n, result_bus_o, result_bus_oe);
  modport host (output conversion_trigger_n, conversion_clock_in, cs_n, rd_n, power_sel,
    input busy_n, result_bus);
endinterface

// ---- logic/result_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic I_REF_CLK, // Clock
  input wire logic I_RST_N, // Async reset, active low
  input wire logic i_in_valid, // Write request
  output logic o_in_ready, // Not full
  input wire logic [WIDTH-1:0] i_in_data, // Write data
  output logic o_out_valid, // Not empty
  input wire logic i_out_ready, // Read accept
  output logic [WIDTH-1:0] o_out_data // Head word
);
  typedef struct packed {
    logic [AW-1:0] wp; // Write pointer
    logic [AW-1:0] rp; // Read pointer
    logic [AW:0] cnt; // Words held
  } fifo_t;
  logic [WIDTH-1:0] mem [DEPTH]; // Word storage
  fifo_t state_r; // Registered pointers and count
  fifo_t state_nxt; // Next pointers and count
  logic wr; // Accepted write
  logic rd; // Accepted read
  assign o_in_ready = (state_r.cnt != DEPTH[AW:0]);
  assign o_out_valid = (state_r.cnt != '0);
  assign o_out_data = mem[state_r.rp];
  assign wr = i_in_valid & o_in_ready;
  assign rd = o_out_valid & i_out_ready;
  // Storage
  always_ff @(posedge I_REF_CLK) begin
    if (wr) begin
      mem[state_r.wp] <= i_in_data;
    end
  end
  // Next pointers and fill count; a write and a read together keep the count
  always_comb begin
    state_nxt = state_r;
    if (wr) begin
      state_nxt.wp = state_r.wp + 1'b1;
    end
    if (rd) begin
      state_nxt.rp = state_r.rp + 1'b1;
    end
    state_nxt.cnt = state_r.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  end
  // Pointer and count register
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule // result_fifo

// ---- logic/sar_conv_dev.sv ----
// Converter end: trigger capture, conversion timing, read port
`include "sar_link_defs.svh"
module sar_conv_dev (
  input wire logic I_REF_CLK, // System clock
  input wire logic I_RST_N, // Async reset, active low
  sar_link_if.dev LNK, // Pins toward the host
  input wire sar_link_pkg::result_t I_SAMPLE, // Quantised analog value
  output logic O_POWER_SAVE, // Power save state
  output logic O_HOLD // Track/hold in hold
);
  import sar_link_pkg::*;
  typedef enum logic [1:0] {D_IDLE = 2'b01, D_CONV = 2'b10} dstate_t;
  typedef struct packed {
    dstate_t st;
    logic trig_q;
    logic clk_q;
    logic [4:0] per;
    result_t held;
    result_t res;
    logic busy_n;
    logic [11:0] oe;
    result_t bus;
    logic psave;
    logic hold; // Track/hold in hold, registered for the output pin
  } dev_t;
  dev_t r, n;
  logic trig_rise;
  logic clk_rise;
  logic sel;
  assign trig_rise = LNK.conversion_trigger_n & ~r.trig_q;
  assign clk_rise = LNK.conversion_clock_in & ~r.clk_q;
  assign sel = ~LNK.cs_n;
  // Next state
  always_comb begin
    n = r;
    n.trig_q = LNK.conversion_trigger_n;
    n.clk_q = LNK.conversion_clock_in;
    n.psave = ~LNK.power_sel;
    unique case (r.st)
      D_IDLE: begin
        if (trig_rise) begin
          n.st = D_CONV;
          n.held = I_SAMPLE;
          n.per = '0;
          n.busy_n = 1'b0;
        end
      end
      D_CONV: begin
        // Triggers ignored while busy
        if (clk_rise) begin
          n.per = r.per + 5'h1;
          if (r.per == 5'(`CONV_PERIODS - 1)) begin
            n.st = D_IDLE;
            n.res = r.held;
            n.busy_n = 1'b1;
          end
        end
      end
    endcase
    // Hold follows the conversion state from the trigger edge on
    n.hold = (n.st == D_CONV);
    // Bus drives only when selected and reading, never while busy
    if (sel && !LNK.rd_n && n.busy_n) begin
      n.oe = '1;
      n.bus = n.res;
    end else begin
      n.oe = '0;
      n.bus = '0;
    end
  end
  // State register
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r <= '{st: D_IDLE, trig_q: 1'b1, clk_q: 1'b0, per: 5'h0, held: 12'h000,
        res: 12'h000, busy_n: 1'b1, oe: 12'h000, bus: 12'h000, psave: 1'b0, hold: 1'b0};
    end else begin
      r <= n;
    end
  end
  assign LNK.busy_n = r.busy_n;
  assign LNK.result_bus_o = r.bus;
  assign LNK.result_bus_oe = r.oe;
  assign O_POWER_SAVE = r.psave;
  assign O_HOLD = r.hold;
endmodule // sar_conv_dev

// ---- logic/sar_conv_host.sv ----
// Host end: clock source, paced triggers, result read into a FIFO
`include "sar_link_defs.svh"
module sar_conv_host (
  input wire logic I_REF_CLK, // System clock
  input wire logic I_RST_N, // Async reset, active low
  sar_link_if.host LNK, // Pins toward the converter
  input wire logic I_RUN, // Enable sampling
  input wire logic I_POWER_SAVE, // Request power save
  output logic O_VALID, // Result available
  input wire logic I_READY, // Consumer accepts result
  output sar_link_pkg::result_t O_DATA // Result word
);
  import sar_link_pkg::*;
  typedef enum logic [3:0] {H_WAIT = 4'b0001, H_TRIG = 4'b0010, H_CONV = 4'b0100,
    H_READ = 4'b1000} hstate_t;
  typedef struct packed {
    hstate_t st;
    logic [5:0] div;
    logic cclk;
    logic [11:0] gap;
    logic trig_n;
    logic cs_n;
    logic rd_n;
    logic psel;
    logic [1:0] rdc;
    logic push;
    result_t word;
  } host_t;
  host_t r, n;
  logic f_ready;
  // Next state
  always_comb begin
    n = r;
    n.push = 1'b0;
    n.psel = ~I_POWER_SAVE;
    // Conversion clock, 50 percent duty
    if (r.div == 6'(`CONV_DIV - 1)) n.div = '0;
    else n.div = r.div + 6'h1;
    n.cclk = (n.div < 6'(`CONV_HIGH_CYC));
    if (r.gap != '0) n.gap = r.gap - 12'h001;
    unique case (r.st)
      H_WAIT: begin
        if (I_RUN && r.gap == '0 && f_ready && LNK.busy_n) begin
          n.st = H_TRIG;
          n.trig_n = 1'b0;
          n.gap = 12'(`SAMPLE_CYC);
        end
      end
      H_TRIG: begin
        n.trig_n = 1'b1;
        n.st = H_CONV;
      end
      H_CONV: begin
        // Busy is trusted only once the converter has had time to lower it
        if (LNK.busy_n && r.gap < 12'(`SAMPLE_CYC - `BUSY_LAG)) begin
          n.st = H_READ;
          n.cs_n = 1'b0;
          n.rd_n = 1'b0;
          n.rdc = '0;
        end
      end
      H_READ: begin
        n.rdc = r.rdc + 2'h1;
        if (r.rdc == 2'(`RD_LAST)) begin
          n.word = LNK.result_bus;
          n.push = 1'b1;
          n.cs_n = 1'b1;
          n.rd_n = 1'b1;
          n.st = H_WAIT;
          if (n.gap < 12'(`ACQ_CYC)) n.gap = 12'(`ACQ_CYC);
        end
      end
    endcase
  end
  // State register
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r <= '{st: H_WAIT, div: 6'h00, cclk: 1'b0, gap: 12'h000, trig_n: 1'b1,
        cs_n: 1'b1, rd_n: 1'b1, psel: 1'b1, rdc: 2'h0, push: 1'b0, word: 12'h000};
    end else begin
      r <= n;
    end
  end
  assign LNK.conversion_trigger_n = r.trig_n;
  assign LNK.conversion_clock_in = r.cclk;
  assign LNK.cs_n = r.cs_n;
  assign LNK.rd_n = r.rd_n;
  assign LNK.power_sel = r.psel;
  // Results toward the consumer; full FIFO stalls triggering
  result_fifo #(.WIDTH(`RES_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) i_result_fifo (
    .I_REF_CLK(I_REF_CLK),
    .I_RST_N(I_RST_N),
    .i_in_valid(r.push),
    .o_in_ready(f_ready),
    .i_in_data(r.word),
    .o_out_valid(O_VALID),
    .i_out_ready(I_READY),
    .o_out_data(O_DATA)
  );
endmodule // sar_conv_host

// ---- test/sar_link_assertions.sv ----
// Checker for the converter link pins
module sar_link_assertions (
  input wire logic I_REF_CLK, // Clock
  input wire logic I_RST_N, // Reset, low
  input wire logic conversion_trigger_n, // Trigger
  input wire logic conversion_clock_in, // Conversion clock
  input wire logic cs_n, // Select
  input wire logic rd_n, // Read strobe
  input wire logic busy_n, // Busy
  input wire logic [11:0] result_bus_oe // Bus enables
);
  timeunit 1ns;
  timeprecision 100ps;
  int ec, bc, ac, tc, hc; // Edges, busy, gap, spacing, high run
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  // Counts around each conversion; gaps start large so the first trigger passes
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ec <= 0;
      bc <= 0;
      ac <= 9999;
      tc <= 9999;
      hc <= 0;
    end else begin
      ec <= busy_n ? 0 : ec + int'($rose(conversion_clock_in));
      bc <= busy_n ? 0 : bc + 1;
      ac <= $rose(busy_n) ? 0 : ac + 1;
      tc <= $rose(conversion_trigger_n) ? 0 : tc + 1;
      hc <= conversion_clock_in ? hc + 1 : 0;
    end
  end
  property p_bus; |result_bus_oe |-> !$past(cs_n) && !$past(rd_n); endproperty
  a_bus: assert property (p_bus) else $error("bus unselected");
  property p_flt; !busy_n |-> result_bus_oe == 12'h000; endproperty
  a_flt: assert property (p_flt) else $error("bus in conversion");
  property p_go; $rose(conversion_trigger_n) && busy_n |-> ##[1:3] !busy_n; endproperty
  a_go: assert property (p_go) else $error("no busy");
  property p_per; $rose(busy_n) |-> ec inside {[26:28]}; endproperty
  a_per: assert property (p_per) else $error("period count");
  property p_max; !busy_n |-> bc < 1500; endproperty
  a_max: assert property (p_max) else $error("too long");
  property p_acq; $rose(conversion_trigger_n) |-> ac >= 500; endproperty
  a_acq: assert property (p_acq) else $error("short acquisition");
  property p_gap; $rose(conversion_trigger_n) |-> tc >= 2000; endproperty
  a_gap: assert property (p_gap) else $error("short spacing");
  property p_duty; $fell(conversion_clock_in) |-> hc inside {[20:30]}; endproperty
  a_duty: assert property (p_duty) else $error("duty");
  c_done: cover property ($rose(busy_n));
  c_read: cover property (|result_bus_oe);
  c_trig: cover property ($rose(conversion_trigger_n));
endmodule // sar_link_assertions

// ---- test/tb_sar_adc_conversion_and_read_port.sv ----
// Bench joining both link ends: fill, stall and drain of results
module tb_sar_adc_conversion_and_read_port;
  timeunit 1ns;
  timeprecision 100ps;
  import sar_link_pkg::*;
  logic ref_clk, rst_n, run, psave_req, ready, valid, power_save, hold; // Bench nets
  result_t sample, data; // Converted value and word read back
  int num_errors, checked, cyc, lows; // Tallies
  result_t vals [8] = '{12'h000, 12'hFFF, 12'hA5A, 12'h5A5, 12'h001, 12'h800, 12'h7FF, 12'h123};
  sar_link_if lnk ();
  sar_conv_dev i_sar_conv_dev (.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .LNK(lnk),
    .I_SAMPLE(sample), .O_POWER_SAVE(power_save), .O_HOLD(hold));
  sar_conv_host i_sar_conv_host (.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .LNK(lnk), .I_RUN(run),
    .I_POWER_SAVE(psave_req), .O_VALID(valid), .I_READY(ready), .O_DATA(data));
  sar_link_assertions i_sar_link_assertions (.I_REF_CLK(ref_clk), .I_RST_N(rst_n),
    .conversion_trigger_n(lnk.conversion_trigger_n), .conversion_clock_in(lnk.conversion_clock_in),
    .cs_n(lnk.cs_n), .rd_n(lnk.rd_n), .busy_n(lnk.busy_n), .result_bus_oe(lnk.result_bus_oe));
  // Compare one value, four-state exact
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    psave_req = 1'b1;
    ready = 1'b0;
    sample = 12'h000;
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("busy", 12'h1, 12'(lnk.busy_n));
    repeat (50) @(posedge ref_clk);
    #1 chk("power select", 12'h0, 12'(lnk.power_sel));
    chk("power save", 12'h1, 12'(power_save));
    psave_req = 1'b0;
    run = 1'b1;
    // Input changes after the trigger must not reach the result
    foreach (vals[k]) begin
      sample = vals[k];
      repeat (3000) if (lnk.busy_n !== 1'b0) begin @(posedge ref_clk); #1; end
      sample = ~vals[k];
      chk("bus", 12'h000, lnk.result_bus);
      chk("hold", 12'h1, 12'(hold));
      chk("power save", 12'h0, 12'(power_save));
      chk("power select", 12'h1, 12'(lnk.power_sel));
      repeat (3000) if (lnk.busy_n !== 1'b1) begin @(posedge ref_clk); #1; end
      chk("hold released", 12'h0, 12'(hold));
      chk("bus unselected", 12'h000, lnk.result_bus);
    end
    // Buffer full: no further conversion may start
    repeat (3000) begin
      @(posedge ref_clk);
      #1 lows += int'(lnk.busy_n !== 1'b1);
    end
    chk("busy while full", 12'h0, 12'(lows));
    run = 1'b0;
    ready = 1'b1;
    foreach (vals[k]) begin
      repeat (100) if (valid !== 1'b1) begin @(posedge ref_clk); #1; end
      chk("word", vals[k], data);
      @(posedge ref_clk);
      #1;
    end
    chk("empty", 12'h0, 12'(valid));
    tally_and_finish;
  end
endmodule // tb_sar_adc_conversion_and_read_port
